/* File: cso_consts.svh */
// Opcodes, cycle counts and reset values of the stack, logic and rotate execution unit.
`ifndef CSO_CONSTS_SVH
`define CSO_CONSTS_SVH
`define CSO_OP_MUL16 8'hF4
`define CSO_OP_OR_FIRST 8'h42
`define CSO_OP_OR_LAST 8'h47
`define CSO_OP_OR_EXT_ER 8'h48
`define CSO_OP_OR_EXT_IM 8'h49
`define CSO_OP_POP_R 8'h50
`define CSO_OP_POP_IR 8'h51
`define CSO_OP_POP_EXT 8'hD8
`define CSO_OP_PUSH_R 8'h70
`define CSO_OP_PUSH_IR 8'h71
`define CSO_OP_PUSH_EXT 8'hC8
`define CSO_OP_RETURN 8'hAF
`define CSO_OP_ROL_R 8'h90
`define CSO_OP_ROL_IR 8'h91
`define CSO_OP_ROLC_R 8'h10
`define CSO_OP_ROLC_IR 8'h11
`define CSO_OP_ROR_R 8'hE0
`define CSO_OP_ROR_IR 8'hE1
`define CSO_OP_RORC_R 8'hC0
`define CSO_OP_RORC_IR 8'hC1
`define CSO_OP_EADDR_BYTE 8'h98
`define CSO_OP_EADDR_PAIR 8'h99
`define CSO_CYC_BAD 4'h1
`define CSO_CYC_REG 4'h2
`define CSO_CYC_IND 4'h3
`define CSO_CYC_OR 4'h3
`define CSO_CYC_OR_IND 4'h4
`define CSO_CYC_RETURN 4'h4
`define CSO_CYC_EADDR_BYTE 4'h3
`define CSO_CYC_EADDR_PAIR 4'h5
`define CSO_CYC_MUL16 4'h8
`define CSO_SP_RST 16'h0000
`define CSO_PC_RST 16'h0000
`endif

/* File: cso_pkg.sv */
// Types shared by the stack, logic and rotate execution unit.
package cso_pkg;
  typedef enum logic [0:0] {
    CSO_IDLE = 1'b0,
    CSO_EXEC = 1'b1
  } cso_state_e;
  typedef enum logic [3:0] {
    CSO_CL_BAD = 4'h0,
    CSO_CL_MUL16 = 4'h1,
    CSO_CL_OR = 4'h2,
    CSO_CL_PUSH = 4'h3,
    CSO_CL_POP = 4'h4,
    CSO_CL_RETURN = 4'h5,
    CSO_CL_ROL = 4'h6,
    CSO_CL_ROLC = 4'h7,
    CSO_CL_ROR = 4'h8,
    CSO_CL_RORC = 4'h9,
    CSO_CL_EADDR_BYTE = 4'hA,
    CSO_CL_EADDR_PAIR = 4'hB
  } cso_class_e;
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } cso_flags_s;
  typedef struct packed {
    logic re;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cso_mem_req_s;
endpackage

/* File: cso_exec.sv */
// Execution unit for multiply, OR, push, pop, return, rotate and effective address.
// ****************************************************************
// Overview of operation
// - Flags follow result, hold, or are forced.
// - Multiply pair bytes, 16-bit product, eight cycles.
// - OR stores dst|src; Z,S follow, V cleared.
// - Push decrements pointer, then writes source byte.
// - Pop reads at pointer, then increments pointer.
// - Return loads counter from stack, pointer plus two.
// - Rotate left: top bit to bit0 and carry.
// - Rotate right: bit0 to top bit and carry.
// - Rotate right through carry, carry to top.
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "cso_consts.svh"
module cso_exec
  import cso_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic start, // Take opcode and operands while idle.
  input wire logic [7:0] opcode, // Opcode to execute.
  input wire logic [7:0] dst_val, // Destination byte operand.
  input wire logic [7:0] src_val, // Source byte operand.
  input wire logic [15:0] pair_val, // Register pair operand.
  input wire logic [7:0] disp, // Signed displacement.
  input wire logic sp_wr, // Load the stack pointer while idle and start is low.
  input wire logic [15:0] sp_wdata, // Stack pointer load value.
  input wire logic [7:0] mem_rdata, // Stack memory read data, one cycle late.
  output logic busy, // Instruction in progress.
  output logic done_q, // Instruction finished, one cycle pulse.
  output logic bad_op_q, // Finished opcode was not handled here.
  output logic [15:0] res_q, // Result for the destination.
  output logic res_we_q, // Result write strobe.
  output logic res_wide_q, // Result is a 16-bit pair.
  output cso_flags_s flags_q, // Flags register.
  output logic [15:0] stack_pointer, // Stack pointer.
  output logic [15:0] program_counter, // Program counter loaded by return.
  output logic pc_load_q, // Program counter load strobe.
  output cso_mem_req_s mem_req // Stack memory request.
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  cso_state_e st_q;
  cso_class_e cls_q;
  cso_class_e cls_d;
  logic [3:0] cyc_q;
  logic [3:0] cyc_d;
  logic [3:0] step_q;
  logic [7:0] dst_q;
  logic [7:0] src_q;
  logic [15:0] pair_q;
  logic [7:0] disp_q;
  logic [7:0] rd_hi_q;
  logic [7:0] rd_lo_q;
  logic [15:0] sp_q;
  logic take;
  logic exec;
  logic last;
  logic [7:0] pop_byte;
  logic [8:0] rot;
  logic [7:0] or_res;

  always_comb
  begin
    cls_d = CSO_CL_BAD;
    cyc_d = `CSO_CYC_BAD;
    if (opcode >= `CSO_OP_OR_FIRST && opcode <= `CSO_OP_OR_LAST)
    begin
      cls_d = CSO_CL_OR;
      cyc_d = opcode[0] ? `CSO_CYC_OR_IND : `CSO_CYC_OR;
    end
    else
    begin
      unique case (opcode)
        `CSO_OP_MUL16: begin cls_d = CSO_CL_MUL16; cyc_d = `CSO_CYC_MUL16; end
        `CSO_OP_OR_EXT_ER, `CSO_OP_OR_EXT_IM: begin cls_d = CSO_CL_OR; cyc_d = `CSO_CYC_OR; end
        `CSO_OP_POP_R, `CSO_OP_POP_EXT: begin cls_d = CSO_CL_POP; cyc_d = `CSO_CYC_REG; end
        `CSO_OP_POP_IR: begin cls_d = CSO_CL_POP; cyc_d = `CSO_CYC_IND; end
        `CSO_OP_PUSH_R, `CSO_OP_PUSH_EXT: begin cls_d = CSO_CL_PUSH; cyc_d = `CSO_CYC_REG; end
        `CSO_OP_PUSH_IR: begin cls_d = CSO_CL_PUSH; cyc_d = `CSO_CYC_IND; end
        `CSO_OP_RETURN: begin cls_d = CSO_CL_RETURN; cyc_d = `CSO_CYC_RETURN; end
        `CSO_OP_ROL_R, `CSO_OP_ROL_IR: cls_d = CSO_CL_ROL;
        `CSO_OP_ROLC_R, `CSO_OP_ROLC_IR: cls_d = CSO_CL_ROLC;
        `CSO_OP_ROR_R, `CSO_OP_ROR_IR: cls_d = CSO_CL_ROR;
        `CSO_OP_RORC_R, `CSO_OP_RORC_IR: cls_d = CSO_CL_RORC;
        `CSO_OP_EADDR_BYTE: begin cls_d = CSO_CL_EADDR_BYTE; cyc_d = `CSO_CYC_EADDR_BYTE; end
        `CSO_OP_EADDR_PAIR: begin cls_d = CSO_CL_EADDR_PAIR; cyc_d = `CSO_CYC_EADDR_PAIR; end
        default: ;
      endcase
      if (cls_d inside {CSO_CL_ROL, CSO_CL_ROLC, CSO_CL_ROR, CSO_CL_RORC})
        cyc_d = opcode[0] ? `CSO_CYC_IND : `CSO_CYC_REG;
    end
  end

  assign take = start && st_q == CSO_IDLE;
  assign exec = st_q == CSO_EXEC;
  assign last = exec && step_q == cyc_q - 4'h1;
  assign busy = exec;
  assign stack_pointer = sp_q;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      st_q <= CSO_IDLE;
    else if (take)
      st_q <= CSO_EXEC;
    else if (last)
      st_q <= CSO_IDLE;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      step_q <= 4'h0;
    else if (exec && !last)
      step_q <= step_q + 4'h1;
    else
      step_q <= 4'h0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cls_q <= CSO_CL_BAD;
      cyc_q <= `CSO_CYC_BAD;
      dst_q <= 8'h00;
      src_q <= 8'h00;
      pair_q <= 16'h0000;
      disp_q <= 8'h00;
    end
    else if (take)
    begin
      cls_q <= cls_d;
      cyc_q <= cyc_d;
      dst_q <= dst_val;
      src_q <= src_val;
      pair_q <= pair_val;
      disp_q <= disp;
    end
  end

  // ****************************************************************
  // Stack memory
  // ****************************************************************
  // Reads return data one cycle after the request, so return reads the
  // high byte at the pointer first and the low byte above it.
  always_comb
  begin
    mem_req.re = exec && ((cls_q == CSO_CL_POP && step_q == 4'h0) ||
                 (cls_q == CSO_CL_RETURN && step_q < 4'h2));
    mem_req.we = exec && cls_q == CSO_CL_PUSH && step_q == 4'h0;
    mem_req.wdata = src_q;
    if (cls_q == CSO_CL_PUSH)
      mem_req.addr = sp_q - 16'h0001;
    else if (cls_q == CSO_CL_RETURN && step_q == 4'h1)
      mem_req.addr = sp_q + 16'h0001;
    else
      mem_req.addr = sp_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rd_hi_q <= 8'h00;
      rd_lo_q <= 8'h00;
    end
    else if (exec && step_q == 4'h1)
      rd_hi_q <= mem_rdata;
    else if (exec && step_q == 4'h2 && cls_q == CSO_CL_RETURN)
      rd_lo_q <= mem_rdata;
  end

  assign pop_byte = (step_q == 4'h1) ? mem_rdata : rd_hi_q;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      sp_q <= `CSO_SP_RST;
    else if (mem_req.we)
      sp_q <= sp_q - 16'h0001;
    else if (last && cls_q == CSO_CL_POP)
      sp_q <= sp_q + 16'h0001;
    else if (last && cls_q == CSO_CL_RETURN)
      sp_q <= sp_q + 16'h0002;
    else if (!exec && !start && sp_wr)
      sp_q <= sp_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      program_counter <= `CSO_PC_RST;
      pc_load_q <= 1'b0;
    end
    else
    begin
      pc_load_q <= last && cls_q == CSO_CL_RETURN;
      if (last && cls_q == CSO_CL_RETURN)
        program_counter <= {rd_hi_q, rd_lo_q};
    end
  end

  // ****************************************************************
  // Results and flags
  // ****************************************************************
  assign or_res = dst_q | src_q;

  always_comb
  begin
    unique case (cls_q)
      CSO_CL_ROL: rot = {dst_q[7], dst_q[6:0], dst_q[7]};
      CSO_CL_ROLC: rot = {dst_q[7], dst_q[6:0], flags_q.c};
      CSO_CL_ROR: rot = {dst_q[0], dst_q[0], dst_q[7:1]};
      CSO_CL_RORC: rot = {dst_q[0], flags_q.c, dst_q[7:1]};
      default: rot = {1'b0, dst_q};
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      res_q <= 16'h0000;
      res_we_q <= 1'b0;
      res_wide_q <= 1'b0;
      done_q <= 1'b0;
      bad_op_q <= 1'b0;
    end
    else
    begin
      done_q <= last;
      bad_op_q <= last && cls_q == CSO_CL_BAD;
      res_we_q <= last && !(cls_q inside {CSO_CL_BAD, CSO_CL_PUSH, CSO_CL_RETURN});
      res_wide_q <= last && (cls_q == CSO_CL_MUL16 || cls_q == CSO_CL_EADDR_PAIR);
      if (last)
      begin
        unique case (cls_q)
          CSO_CL_MUL16: res_q <= 16'(pair_q[15:8] * pair_q[7:0]);
          CSO_CL_OR: res_q <= {8'h00, or_res};
          CSO_CL_POP: res_q <= {8'h00, pop_byte};
          CSO_CL_ROL, CSO_CL_ROLC, CSO_CL_ROR, CSO_CL_RORC: res_q <= {8'h00, rot[7:0]};
          CSO_CL_EADDR_BYTE: res_q <= {8'h00, src_q + disp_q};
          CSO_CL_EADDR_PAIR: res_q <= pair_q + {{8{disp_q[7]}}, disp_q};
          default: ;
        endcase
      end
    end
  end

  // Only OR and the rotates touch flags; all other classes hold them.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      flags_q <= '0;
    else if (last && cls_q == CSO_CL_OR)
    begin
      flags_q.z <= or_res == 8'h00;
      flags_q.s <= or_res[7];
      flags_q.v <= 1'b0;
    end
    else if (last && cls_q inside {CSO_CL_ROL, CSO_CL_ROLC, CSO_CL_ROR, CSO_CL_RORC})
    begin
      flags_q.c <= rot[8];
      flags_q.z <= rot[7:0] == 8'h00;
      flags_q.s <= rot[7];
      flags_q.v <= rot[7] ^ dst_q[7];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_mul16_time;
    @(posedge mclk) disable iff (!rstn)
    take && opcode == `CSO_OP_MUL16 |-> ##9 (done_q && res_wide_q);
  endproperty
  a_mul16_time: assert property (p_mul16_time) else $error("multiply not done in 8 cycles");

  property p_mul16_flags;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_MUL16 |=> flags_q == $past(flags_q) &&
      res_q == $past(pair_q[15:8]) * $past(pair_q[7:0]);
  endproperty
  a_mul16_flags: assert property (p_mul16_flags) else $error("multiply result or flags wrong");

  property p_or;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_OR |=> res_q[7:0] == $past(or_res) && !flags_q.v && flags_q.c == $past(flags_q.c) && flags_q.s == res_q[7];
  endproperty
  a_or: assert property (p_or) else $error("OR result or flags wrong");

  property p_push;
    @(posedge mclk) disable iff (!rstn)
    mem_req.we |-> mem_req.addr == sp_q - 16'h0001 ##1 sp_q == $past(mem_req.addr) && $stable(flags_q);
  endproperty
  a_push: assert property (p_push) else $error("push address or pointer wrong");

  property p_pop;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_POP |=> sp_q == $past(sp_q) + 16'h0001 && res_q[7:0] == $past(pop_byte);
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer or data wrong");

  property p_return;
    @(posedge mclk) disable iff (!rstn)
    take && opcode == `CSO_OP_RETURN |-> ##5 (pc_load_q && sp_q == $past(sp_q, 5) + 16'h0002);
  endproperty
  a_return: assert property (p_return) else $error("return not done in 4 cycles");

  property p_rol;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_ROL |=> res_q[7:0] == {$past(dst_q[6:0]), $past(dst_q[7])} &&
      flags_q.c == res_q[0];
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");

  property p_ror;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_ROR |=> res_q[7:0] == {$past(dst_q[0]), $past(dst_q[7:1])} &&
      flags_q.c == res_q[7];
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");

  property p_rorc;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_RORC |=> res_q[7] == $past(flags_q.c) && flags_q.c == $past(dst_q[0]) &&
      flags_q.z == (res_q[7:0] == 8'h00);
  endproperty
  a_rorc: assert property (p_rorc) else $error("rotate right through carry wrong");

  property p_rolc;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_ROLC |=> res_q[0] == $past(flags_q.c) && flags_q.c == $past(dst_q[7]) &&
      flags_q.v == (res_q[7] ^ $past(dst_q[7]));
  endproperty
  a_rolc: assert property (p_rolc) else $error("rotate left through carry wrong");

  property p_eaddr;
    @(posedge mclk) disable iff (!rstn)
    last && cls_q == CSO_CL_EADDR_PAIR |=> res_q == $past(pair_q) + {{8{$past(disp_q[7])}}, $past(disp_q)} &&
      $stable(flags_q);
  endproperty
  a_eaddr: assert property (p_eaddr) else $error("effective address wrong");
endmodule
`default_nettype wire

/* File: cso_stack_mem.sv */
// Stack memory model that answers the execution unit's byte requests.
`timescale 1ns/10ps
`default_nettype none
module cso_stack_mem
  import cso_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire cso_mem_req_s mem_req, // Request from the unit.
  output logic [7:0] mem_rdata // Read byte, one cycle after the request.
);
  // ********************
  // Storage
  // ********************
  logic [7:0] mem [0:65535];

  // A plain always block, so that the bench may preload bytes for a return.
  always @(posedge mclk)
  begin
    if (mem_req.we)
      mem[mem_req.addr] <= mem_req.wdata;
    // Outside a read the line shows the inverse of its last value, so the last read byte shows again every other cycle.
    mem_rdata <= mem_req.re ? mem[mem_req.addr] : ~mem_rdata;
  end
endmodule
`default_nettype wire

/* File: cso_exec_test.sv */
// Self-checking bench for the stack, logic and rotate execution unit.
`timescale 1ns/10ps
`default_nettype none
module cso_exec_test
  import cso_pkg::*;
();
  // ********************
  // Stimulus and checks
  // ********************
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic sp_wr = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] dst_val = 8'h00;
  logic [7:0] src_val = 8'h00;
  logic [7:0] disp = 8'h00;
  logic [15:0] pair_val = 16'h0000;
  logic [15:0] sp_wdata = 16'h0000;
  logic [7:0] mem_rdata;
  logic busy, done_q, bad_op_q, res_we_q, res_wide_q, pc_load_q;
  logic [15:0] res_q, stack_pointer, program_counter;
  cso_flags_s flags_q;
  cso_flags_s fx;
  cso_mem_req_s mem_req;
  int errors = 0;
  int n_compared = 0;

  always #5 mclk = ~mclk;

  cso_exec DUT (.mclk, .rstn, .start, .opcode, .dst_val, .src_val, .pair_val, .disp, .sp_wr,
    .sp_wdata, .mem_rdata, .busy, .done_q, .bad_op_q, .res_q, .res_we_q, .res_wide_q,
    .flags_q, .stack_pointer, .program_counter, .pc_load_q, .mem_req);

  cso_stack_mem mem_m (.mclk, .mem_req, .mem_rdata);

  task automatic stop_test();
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The caller sets fx to the flags it expects; the next start goes out in the done cycle.
  task automatic run(input logic [7:0] op, d, s, input logic [15:0] p, input logic [7:0] x,
    input int n);
    int k;
    k = 0;
    opcode = op;
    dst_val = d;
    src_val = s;
    pair_val = p;
    disp = x;
    start = 1'b1;
    @(posedge mclk);
    #1;
    start = 1'b0;
    cmp("busy", 16'h0001, {15'h0000, busy});
    do
    begin
      @(posedge mclk);
      #1;
      k++;
    end while (done_q !== 1'b1 && k < 20);
    cmp("cycles", 16'(n), 16'(k));
    cmp("idle", 16'h0000, {15'h0000, busy});
    cmp("flags", {10'h000, fx}, {10'h000, flags_q});
  endtask

  task automatic t_rotate();
    logic [7:0] ops [8] = '{8'h90, 8'h10, 8'hE0, 8'hC0, 8'h91, 8'h11, 8'hE1, 8'hC1};
    logic [7:0] xs [8] = '{8'h81, 8'h40, 8'h01, 8'h02, 8'h00, 8'hFE, 8'h7F, 8'h80};
    logic [7:0] x;
    logic [8:0] r;
    for (int i = 0; i < 8; i++)
    begin
      x = xs[i];
      case (ops[i][7:4])
        4'h9: r = {x[7], x[6:0], x[7]};
        4'h1: r = {x[7], x[6:0], fx.c};
        4'hE: r = {x[0], x[0], x[7:1]};
        default: r = {x[0], fx.c, x[7:1]};
      endcase
      fx.c = r[8];
      fx.z = r[7:0] == 8'h00;
      fx.s = r[7];
      fx.v = r[7] ^ x[7];
      run(ops[i], x, 8'h00, 16'h0000, 8'h00, ops[i][0] ? 3 : 2);
      cmp("rotate", {8'h00, r[7:0]}, {8'h00, res_q[7:0]});
      cmp("write", 16'h0001, {15'h0000, res_we_q});
    end
  endtask

  task automatic t_or();
    logic [7:0] d, s;
    fx = 6'h24;
    run(8'h90, 8'h80, 8'h00, 16'h0000, 8'h00, 2);
    for (int i = 0; i < 8; i++)
    begin
      d = {i[2:0], 5'h00};
      s = {7'h00, i[0]};
      fx.z = (d | s) == 8'h00;
      fx.s = d[7];
      fx.v = 1'b0;
      run(8'h42 + 8'(i), d, s, 16'h0000, 8'h00, (i[0] && i < 6) ? 4 : 3);
      cmp("or", {8'h00, d | s}, {8'h00, res_q[7:0]});
    end
  endtask

  task automatic t_arith();
    run(8'hF4, 8'h00, 8'h00, 16'hFFFF, 8'h00, 8);
    cmp("product", 16'hFE01, res_q);
    cmp("wide", 16'h0001, {15'h0000, res_wide_q});
    run(8'hF4, 8'h00, 8'h00, 16'h0C0B, 8'h00, 8);
    cmp("product", 16'h0084, res_q);
    run(8'h98, 8'h00, 8'h10, 16'h0000, 8'hFE, 3);
    cmp("address", 16'h000E, {8'h00, res_q[7:0]});
    run(8'h99, 8'h00, 8'h00, 16'h1000, 8'h80, 5);
    cmp("address", 16'h0F80, res_q);
    run(8'h00, 8'h00, 8'h00, 16'h0000, 8'h00, 1);
    cmp("bad", 16'h0001, {15'h0000, bad_op_q});
    cmp("write", 16'h0000, {15'h0000, res_we_q});
  endtask

  task automatic t_stack();
    logic [7:0] pu [3] = '{8'h70, 8'hC8, 8'h71};
    logic [7:0] po [3] = '{8'h50, 8'hD8, 8'h51};
    logic [7:0] dv [3] = '{8'hA5, 8'h5A, 8'h3C};
    sp_wr = 1'b1;
    sp_wdata = 16'h0100;
    @(posedge mclk);
    #1;
    sp_wr = 1'b0;
    cmp("sp", 16'h0100, stack_pointer);
    for (int i = 0; i < 3; i++)
    begin
      run(pu[i], 8'h00, dv[i], 16'h0000, 8'h00, pu[i][0] ? 3 : 2);
      cmp("sp", 16'h00FF - 16'(i), stack_pointer);
      cmp("stacked", {8'h00, dv[i]}, {8'h00, mem_m.mem[16'h00FF - 16'(i)]});
    end
    for (int i = 0; i < 3; i++)
    begin
      run(po[i], 8'h00, 8'h00, 16'h0000, 8'h00, po[i][0] ? 3 : 2);
      cmp("popped", {8'h00, dv[2 - i]}, {8'h00, res_q[7:0]});
      cmp("sp", 16'h00FE + 16'(i), stack_pointer);
    end
    mem_m.mem[16'h0100] = 8'h12;
    mem_m.mem[16'h0101] = 8'h34;
    run(8'hAF, 8'h00, 8'h00, 16'h0000, 8'h00, 4);
    cmp("pc", 16'h1234, program_counter);
    cmp("pc load", 16'h0001, {15'h0000, pc_load_q});
    cmp("sp", 16'h0102, stack_pointer);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    #1;
    rstn = 1'b1;
    fx = 6'h00;
    cmp("flags", 16'h0000, {10'h000, flags_q});
    t_rotate();
    t_or();
    t_arith();
    t_stack();
    stop_test();
  end

  initial
  begin
    #100000;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
